// file: rtl/bcta_pkg.sv
/*
 * bcta_pkg: constants shared by the break count, trace and space id block.
 * assumes a 32-bit AXI4-Lite register bus and a 50 MHz core clock.
 */
package bcta_pkg;
    // register bus geometry
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned STRB_W      = DATA_W / 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_EXEC_COUNT    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SOURCE_TRACE  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DEST_TRACE    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CHAN_A_ID     = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CHAN_B_ID     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BREAK_CONTROL = 8'h14;

    // execution counter field
    localparam int unsigned        COUNT_W     = 12;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h000;
    localparam logic [COUNT_W-1:0] COUNT_ONE   = 12'h001;

    // trace word layout
    localparam int unsigned TRACE_DEPTH = 8;
    localparam int unsigned VALID_BIT   = 31;
    localparam int unsigned PTR_HI      = 30;
    localparam int unsigned PTR_LO      = 28;
    localparam int unsigned PTR_W       = PTR_HI - PTR_LO + 1;
    localparam int unsigned FADDR_W     = 28;

    // break control bit positions
    localparam int unsigned CTRL_COUNT_BREAK_EN = 0;
    localparam int unsigned CTRL_TRACE_EN       = 11;
    localparam int unsigned CTRL_CHAN_B_ID_MASK = 20;
    localparam int unsigned CTRL_CHAN_A_ID_MASK = 21;
    localparam logic [DATA_W-1:0] CTRL_WRITABLE = 32'h0030_0801;
    localparam logic [DATA_W-1:0] CTRL_RESET    = 32'h0000_0000;

    // space identifier width
    localparam int unsigned ID_W = 8;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/bcta_top.sv
/*
 * bcta_top: execution count break on channel b, branch trace queues and
 * per-channel space identifier compare, with an AXI4-Lite register slave.
 * assumes core fetch/branch/match signals come from logic on aclk.
 */
// Behaviour
// - twelve-bit count of channel b matches
// - power-on reset clears execution counter
// - each channel b match decrements a nonzero counter while count break enabled
// - break fires when match meets count one
// - counter bits 15..12 read zero, write zero
// - counting only while count break enabled
// - source entry captures three-bit decode pointer
// - source bits 27..0 hold last fetch
// - even pointer is buffer, odd plus two
// - source valid sets on capture, clears on read
// - resets clear valid flags, keep other bits
// - source queue eight deep, shifts per branch
// - destination queue eight deep, shifts together
// - destination bits 27..0 hold first fetch after
// - destination valid sets on capture, clears on read
// - destination bits 30..28 read zero
// - channel a space id register, not reset
// - channel b space id register, not reset
// - control bit 0 enables count break
// - control bit 21 masks channel a id
// - trace capture only while control bit 11 set
`timescale 1ns/1ns
module bcta_top #(
    parameter int unsigned DEPTH = bcta_pkg::TRACE_DEPTH
) (
    // clock, reset, enable
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    input  wire logic                               clk_en,
    input  wire logic                               manual_reset_n,
    // core fetch and branch
    input  wire logic                               fetch_valid,
    input  wire logic [bcta_pkg::FADDR_W-1:0]       fetch_addr,
    input  wire logic                               branch_taken,
    input  wire logic [bcta_pkg::PTR_W-1:0]         decode_pointer,
    // core match inputs
    input  wire logic                               chan_a_hit,
    input  wire logic                               chan_b_hit,
    input  wire logic [bcta_pkg::ID_W-1:0]          core_space_id,
    // break requests
    output logic                                    break_a_q,
    output logic                                    break_b_q,
    // axi write address and data
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    input  wire logic [bcta_pkg::ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    input  wire logic [bcta_pkg::DATA_W-1:0]        s_axi_wdata,
    input  wire logic [bcta_pkg::STRB_W-1:0]        s_axi_wstrb,
    // axi write response
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    output logic [1:0]                              s_axi_bresp,
    // axi read
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    input  wire logic [bcta_pkg::ADDR_W-1:0]        s_axi_araddr,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    output logic [bcta_pkg::DATA_W-1:0]             s_axi_rdata,
    output logic [1:0]                              s_axi_rresp
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // byte-lane merge of a write into an old word
    function automatic logic [bcta_pkg::DATA_W-1:0] merge_strb(
        input logic [bcta_pkg::DATA_W-1:0] old_w,
        input logic [bcta_pkg::DATA_W-1:0] new_w,
        input logic [bcta_pkg::STRB_W-1:0] strb
    );
        logic [bcta_pkg::DATA_W-1:0] res;
        res = old_w;
        for (int b = 0; b < bcta_pkg::STRB_W; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // true when the word offset names a register
    function automatic logic is_mapped(input logic [bcta_pkg::ADDR_W-1:0] a);
        return a == bcta_pkg::OFS_EXEC_COUNT || a == bcta_pkg::OFS_SOURCE_TRACE
            || a == bcta_pkg::OFS_DEST_TRACE || a == bcta_pkg::OFS_CHAN_A_ID
            || a == bcta_pkg::OFS_CHAN_B_ID || a == bcta_pkg::OFS_BREAK_CONTROL;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [bcta_pkg::COUNT_W-1:0] count_q,      count_d;      // execution counter
    logic [bcta_pkg::DATA_W-1:0]  ctrl_q,       ctrl_d;       // break control
    logic [bcta_pkg::ID_W-1:0]    id_a_q,       id_a_d;       // channel a space id
    logic [bcta_pkg::ID_W-1:0]    id_b_q,       id_b_d;       // channel b space id
    logic [bcta_pkg::DATA_W-1:0]  src_q [DEPTH];              // source queue, 0 newest
    logic [bcta_pkg::DATA_W-1:0]  src_d [DEPTH];
    logic [bcta_pkg::DATA_W-1:0]  dst_q [DEPTH];              // destination queue
    logic [bcta_pkg::DATA_W-1:0]  dst_d [DEPTH];
    logic                         dst_pend_q,   dst_pend_d;   // waiting for first fetch
    logic [bcta_pkg::FADDR_W-1:0] last_fetch_q, last_fetch_d; // newest fetch address
    logic                         break_a_d,    break_b_d;

    // bus state
    logic                         aw_have_q,    aw_have_d;
    logic [bcta_pkg::ADDR_W-1:0]  aw_addr_q,    aw_addr_d;
    logic                         w_have_q,     w_have_d;
    logic [bcta_pkg::DATA_W-1:0]  w_data_q,     w_data_d;
    logic [bcta_pkg::STRB_W-1:0]  w_strb_q,     w_strb_d;
    logic                         awready_d,    wready_d;
    logic                         bvalid_d,     arready_d,    rvalid_d;
    logic [1:0]                   bresp_d,      rresp_d;
    logic [bcta_pkg::DATA_W-1:0]  rdata_d;

    // strobes from bus group to core group
    logic                         wr_fire;      // write performed this cycle
    logic                         cnt_wr;       // counter written
    logic                         src_rd;       // source trace read
    logic                         dst_rd;       // destination trace read
    logic                         chan_a_ok;    // channel a with id check
    logic                         chan_b_ok;    // channel b with id check
    logic [bcta_pkg::FADDR_W-1:0] src_addr;     // source address for capture
    logic [bcta_pkg::DATA_W-1:0]  cnt_word;     // counter write merged into a word

    ////////////////////////////////////////////////////////////////////////
    // register bus: aw and w are latched independently, write when both held

    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = s_axi_bvalid;
        bresp_d   = s_axi_bresp;
        rvalid_d  = s_axi_rvalid;
        rresp_d   = s_axi_rresp;
        rdata_d   = s_axi_rdata;
        ctrl_d    = ctrl_q;
        id_a_d    = id_a_q;
        id_b_d    = id_b_q;
        wr_fire   = 1'b0;
        cnt_wr    = 1'b0;
        src_rd    = 1'b0;
        dst_rd    = 1'b0;
        // response taken frees the write path
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        // perform write in the same cycle both halves are held
        if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            wr_fire   = 1'b1;
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = is_mapped(aw_addr_q) ? bcta_pkg::RESP_OKAY : bcta_pkg::RESP_SLVERR;
            unique case (aw_addr_q)
                bcta_pkg::OFS_EXEC_COUNT: begin
                    cnt_wr = 1'b1;
                end
                bcta_pkg::OFS_CHAN_A_ID: begin
                    id_a_d = w_strb_q[0] ? w_data_q[bcta_pkg::ID_W-1:0] : id_a_q;
                end
                bcta_pkg::OFS_CHAN_B_ID: begin
                    id_b_d = w_strb_q[0] ? w_data_q[bcta_pkg::ID_W-1:0] : id_b_q;
                end
                bcta_pkg::OFS_BREAK_CONTROL: begin
                    ctrl_d = merge_strb(ctrl_q, w_data_q, w_strb_q) & bcta_pkg::CTRL_WRITABLE;
                end
                default: begin
                    // trace words are read only, unmapped answer slverr
                end
            endcase
        end
        // one read at a time; data captured at the address handshake
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = is_mapped(s_axi_araddr) ? bcta_pkg::RESP_OKAY : bcta_pkg::RESP_SLVERR;
            rdata_d  = '0;
            unique case (s_axi_araddr)
                bcta_pkg::OFS_EXEC_COUNT: begin
                    rdata_d[bcta_pkg::COUNT_W-1:0] = count_q;
                end
                bcta_pkg::OFS_SOURCE_TRACE: begin
                    rdata_d = src_q[0];
                    src_rd  = 1'b1;
                end
                bcta_pkg::OFS_DEST_TRACE: begin
                    rdata_d = dst_q[0];
                    dst_rd  = 1'b1;
                end
                bcta_pkg::OFS_CHAN_A_ID: begin
                    rdata_d[bcta_pkg::ID_W-1:0] = id_a_q;
                end
                bcta_pkg::OFS_CHAN_B_ID: begin
                    rdata_d[bcta_pkg::ID_W-1:0] = id_b_q;
                end
                bcta_pkg::OFS_BREAK_CONTROL: begin
                    rdata_d = ctrl_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
        // ready is offered only while the holding slot is free
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // bus registers; space ids are deliberately left out of reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= bcta_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= bcta_pkg::RESP_OKAY;
            s_axi_rdata   <= '0;
            aw_addr_q     <= '0;
            w_data_q      <= '0;
            w_strb_q      <= '0;
            ctrl_q        <= bcta_pkg::CTRL_RESET;
        end else if (clk_en) begin
            aw_have_q     <= aw_have_d;
            w_have_q      <= w_have_d;
            s_axi_awready <= awready_d;
            s_axi_wready  <= wready_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_bresp   <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid  <= rvalid_d;
            s_axi_rresp   <= rresp_d;
            s_axi_rdata   <= rdata_d;
            aw_addr_q     <= aw_addr_d;
            w_data_q      <= w_data_d;
            w_strb_q      <= w_strb_d;
            ctrl_q        <= ctrl_d;
        end
    end

    // space id registers hold whatever software last wrote, across resets
    always_ff @(posedge aclk) begin
        if (clk_en) begin
            id_a_q <= id_a_d;
            id_b_q <= id_b_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // break count and trace capture

    always_comb begin
        count_d      = count_q;
        last_fetch_d = last_fetch_q;
        dst_pend_d   = dst_pend_q;
        src_d        = src_q;
        dst_d        = dst_q;
        break_b_d    = 1'b0;
        // id compare unless masked
        chan_a_ok = chan_a_hit && (ctrl_q[bcta_pkg::CTRL_CHAN_A_ID_MASK] || core_space_id == id_a_q);
        chan_b_ok = chan_b_hit && (ctrl_q[bcta_pkg::CTRL_CHAN_B_ID_MASK] || core_space_id == id_b_q);
        break_a_d = chan_a_ok;
        // counting only gates channel b while enabled
        if (chan_b_ok) begin
            if (!ctrl_q[bcta_pkg::CTRL_COUNT_BREAK_EN]) begin
                break_b_d = 1'b1;
            end else begin
                break_b_d = (count_q == bcta_pkg::COUNT_ONE);
                // a zero count never breaks and does not wrap
                if (count_q != bcta_pkg::COUNT_RESET) begin
                    count_d = count_q - bcta_pkg::COUNT_ONE;
                end
            end
        end
        // software write wins over a same-cycle decrement; high bits dropped
        cnt_word = merge_strb({{(bcta_pkg::DATA_W-bcta_pkg::COUNT_W){1'b0}}, count_q}, w_data_q, w_strb_q);
        if (cnt_wr) begin
            count_d = cnt_word[bcta_pkg::COUNT_W-1:0];
        end
        // a read clears the newest entry's flag before any shift
        if (src_rd) begin
            src_d[0][bcta_pkg::VALID_BIT] = 1'b0;
        end
        if (dst_rd) begin
            dst_d[0][bcta_pkg::VALID_BIT] = 1'b0;
        end
        // a fetch in the branch cycle still counts as before the branch
        src_addr = fetch_valid ? fetch_addr : last_fetch_q;
        if (fetch_valid) begin
            last_fetch_d = fetch_addr;
        end
        if (branch_taken && ctrl_q[bcta_pkg::CTRL_TRACE_EN]) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                src_d[i] = src_d[i-1];
                dst_d[i] = dst_d[i-1];
            end
            src_d[0] = {1'b1, decode_pointer, src_addr};
            dst_d[0] = {1'b0, {bcta_pkg::PTR_W{1'b0}}, dst_q[0][bcta_pkg::FADDR_W-1:0]};
            dst_pend_d = 1'b1;
        end else if (dst_pend_q && fetch_valid) begin
            // set wins over a read clear in the same cycle
            dst_d[0] = {1'b1, {bcta_pkg::PTR_W{1'b0}}, fetch_addr};
            dst_pend_d = 1'b0;
        end
        // manual reset drops only the flags and the pending capture
        if (!manual_reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                src_d[i][bcta_pkg::VALID_BIT] = 1'b0;
                dst_d[i][bcta_pkg::VALID_BIT] = 1'b0;
            end
            dst_pend_d = 1'b0;
        end
    end

    // trace data bits keep their value through reset, only flags clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q    <= bcta_pkg::COUNT_RESET;
            dst_pend_q <= 1'b0;
            break_a_q  <= 1'b0;
            break_b_q  <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                src_q[i][bcta_pkg::VALID_BIT] <= 1'b0;
                dst_q[i][bcta_pkg::VALID_BIT] <= 1'b0;
            end
        end else if (clk_en) begin
            count_q      <= count_d;
            dst_pend_q   <= dst_pend_d;
            last_fetch_q <= last_fetch_d;
            break_a_q    <= break_a_d;
            break_b_q    <= break_b_d;
            src_q        <= src_d;
            dst_q        <= dst_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_COUNT_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> count_q == bcta_pkg::COUNT_RESET)
        else $error("counter not zero after reset");

    AST_COUNT_DEC: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && chan_b_ok && ctrl_q[bcta_pkg::CTRL_COUNT_BREAK_EN] && !cnt_wr && count_q > bcta_pkg::COUNT_ONE
        |=> count_q == $past(count_q) - bcta_pkg::COUNT_ONE)
        else $error("counter did not step down on match");

    AST_BREAK_AT_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && chan_b_ok && ctrl_q[bcta_pkg::CTRL_COUNT_BREAK_EN]
        |=> break_b_q == ($past(count_q) == bcta_pkg::COUNT_ONE))
        else $error("count break fired at wrong count");

    AST_COUNT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && chan_b_ok && !ctrl_q[bcta_pkg::CTRL_COUNT_BREAK_EN] && !cnt_wr
        |=> break_b_q && $stable(count_q))
        else $error("disabled count still gated the break");

    AST_SRC_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && manual_reset_n && branch_taken && ctrl_q[bcta_pkg::CTRL_TRACE_EN]
        |=> src_q[0][bcta_pkg::VALID_BIT] && src_q[0][bcta_pkg::PTR_HI:bcta_pkg::PTR_LO] == $past(decode_pointer)
            && src_q[1][bcta_pkg::VALID_BIT] == ($past(src_q[0][bcta_pkg::VALID_BIT]) && !$past(src_rd))
            && (!$past(src_q[0][bcta_pkg::VALID_BIT])
                || src_q[1][bcta_pkg::PTR_HI:0] == $past(src_q[0][bcta_pkg::PTR_HI:0])))
        else $error("source entry not captured");

    AST_SRC_READ_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && src_rd && !branch_taken ##1 s_axi_rvalid
        |-> !src_q[0][bcta_pkg::VALID_BIT])
        else $error("source flag survived a read");

    AST_DST_FILL: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && manual_reset_n && dst_pend_q && fetch_valid && !branch_taken
        |=> dst_q[0][bcta_pkg::VALID_BIT] && dst_q[0][bcta_pkg::FADDR_W-1:0] == $past(fetch_addr))
        else $error("destination not filled by first fetch");

    AST_DST_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && dst_q[0][bcta_pkg::VALID_BIT] |-> dst_q[0][bcta_pkg::PTR_HI:bcta_pkg::PTR_LO] == '0)
        else $error("destination reserved bits not zero");

    AST_MANUAL_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && !manual_reset_n |=> !src_q[0][bcta_pkg::VALID_BIT] && !dst_q[DEPTH-1][bcta_pkg::VALID_BIT])
        else $error("manual reset left a valid flag");

    AST_ID_MISS: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && chan_a_hit && !ctrl_q[bcta_pkg::CTRL_CHAN_A_ID_MASK] && core_space_id != id_a_q
        |=> !break_a_q)
        else $error("channel a broke with wrong id");

endmodule

// file: verification/bcta_core_model.sv
/* bcta_core_model: fetch, branch and match side of the core.
   assumes go pulses are at least four cycles apart. */
`timescale 1ns/1ns
module bcta_core_model (
    // requests from the bench
    input  wire logic        aclk,
    input  wire logic        go,
    input  wire logic        hit,
    input  wire logic [2:0]  ptr,
    input  wire logic [27:0] src,
    input  wire logic [27:0] dst,
    // core side signals
    output logic             fv = 1'b0,
    output logic             bt = 1'b0,
    output logic             ha = 1'b0,
    output logic             hb = 1'b0,
    output logic [27:0]      fa = 28'h0,
    output logic [2:0]       dp = 3'h0
);
    logic [1:0] st_q = 2'h0;  // step: 1 fetch, 2 branch, 3 fetch
    ////////////////////////////////////////////////////////////////////////////
    // idle address and pointer toggle so a stale value never looks fresh
    always @(posedge aclk) begin
        st_q <= go ? 2'h1 : (st_q == 2'h0 ? 2'h0 : st_q + 2'h1);
        fv <= (st_q == 2'h1) || (st_q == 2'h3);
        bt <= st_q == 2'h2;
        fa <= st_q == 2'h1 ? src : (st_q == 2'h3 ? dst : ~fa);
        dp <= st_q == 2'h2 ? ptr : ~dp;
        ha <= hit;
        hb <= hit;
    end
endmodule

// file: verification/bcta_top_bench.sv
/* bcta_top_bench: register, count break and trace checks.
   assumes bcta_core_model plays the core; reads checked from a queue. */
`timescale 1ns/1ns
module bcta_top_bench;
    logic        aclk, aresetn, mrn, awv, wv, bre, arv, rre, hit, go;  // bench driven
    logic [7:0]  awa, ara, sid, w;
    logic [31:0] wd, rd;
    logic [2:0]  ptr, dp;
    logic [27:0] src, dst, fa;
    logic [30:0] old;                                        // saved entry
    logic        awr, wr, bv, arr, rv, fv, bt, ha, hb, bka, bkb;  // seen
    logic [1:0]  bresp, rresp;
    logic [33:0] exp_q[$];                                   // {resp, data}
    int          err_count, tests_run, na, nb, na0;
    bcta_top bcta_top_i (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .manual_reset_n(mrn),
        .fetch_valid(fv), .fetch_addr(fa), .branch_taken(bt), .decode_pointer(dp),
        .chan_a_hit(ha), .chan_b_hit(hb), .core_space_id(sid), .break_a_q(bka), .break_b_q(bkb),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rresp));
    bcta_core_model bcta_core_model_i (.aclk(aclk), .go(go), .hit(hit), .ptr(ptr), .src(src),
        .dst(dst), .fv(fv), .bt(bt), .ha(ha), .hb(hb), .fa(fa), .dp(dp));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic guard(input int n);  // a spent wait ends the run
        if (n >= 50) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    // write: address and data together, each released when taken
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic [1:0] er;
        er = (a > bcta_pkg::OFS_BREAK_CONTROL) ? bcta_pkg::RESP_SLVERR : bcta_pkg::RESP_OKAY;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        for (n = 0; n < 50 && !(bv && !awv && !wv); n++) begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end
        bre <= 1'b0;
        guard(n);
        check("bresp", 34'(bresp), 34'(er));
    endtask
    // read: expectation noted first, monitor compares on the r handshake
    task automatic rd_reg(input logic [7:0] a, input logic [33:0] e);
        int n;
        exp_q.push_back(e);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        for (n = 0; n < 50 && !(rv && !arv); n++) begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end
        rre <= 1'b0;
        guard(n);
    endtask
    task automatic branch_once();  // random pointer and both fetch addresses
        @(posedge aclk);
        ptr <= 3'($urandom);
        src <= 28'($urandom);
        dst <= 28'($urandom);
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        if (rv && rre) check("read", {rresp, rd}, exp_q.pop_front());
        na += (bka === 1'b1);
        nb += (bkb === 1'b1);
    end
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        {aresetn, mrn, awv, wv, bre, arv, rre, hit, go} = 9'h080;
        {awa, ara, sid, wd, ptr, src, dst} = '0;
        void'($urandom(69));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        sid <= 8'($urandom);
        rd_reg(bcta_pkg::OFS_EXEC_COUNT, 34'h0);
        wr_reg(bcta_pkg::OFS_EXEC_COUNT, 32'h0000_0003);
        rd_reg(bcta_pkg::OFS_EXEC_COUNT, 34'h3);
        wr_reg(bcta_pkg::OFS_BREAK_CONTROL, 32'h0030_0801);
        // break only on the third hit; a count of zero holds and never breaks
        for (int i = 1; i <= 4; i++) begin
            @(posedge aclk);
            hit <= 1'b1;
            @(posedge aclk);
            hit <= 1'b0;
            repeat (4) @(posedge aclk);
            check("break_b", 34'(nb), 34'(i >= 3));
            check("break_a", 34'(na), 34'(i));
        end
        rd_reg(bcta_pkg::OFS_EXEC_COUNT, 34'h0);
        branch_once();
        rd_reg(bcta_pkg::OFS_SOURCE_TRACE, {3'h1, ptr, src});
        rd_reg(bcta_pkg::OFS_SOURCE_TRACE, {3'h0, ptr, src});
        rd_reg(bcta_pkg::OFS_DEST_TRACE, {3'h1, 3'h0, dst});
        branch_once();
        @(posedge aclk);
        mrn <= 1'b0;
        @(posedge aclk);
        mrn <= 1'b1;
        rd_reg(bcta_pkg::OFS_SOURCE_TRACE, {3'h0, ptr, src});
        rd_reg(bcta_pkg::OFS_DEST_TRACE, {6'h0, dst});
        // trace off: a branch leaves the newest entry alone
        wr_reg(bcta_pkg::OFS_BREAK_CONTROL, 32'h0030_0001);
        old = {ptr, src};
        branch_once();
        rd_reg(bcta_pkg::OFS_SOURCE_TRACE, {3'h0, old});
        for (int k = 0; k < 2; k++) begin
            w = 8'($urandom);
            wr_reg(k ? bcta_pkg::OFS_CHAN_B_ID : bcta_pkg::OFS_CHAN_A_ID, {24'h0, w});
            rd_reg(k ? bcta_pkg::OFS_CHAN_B_ID : bcta_pkg::OFS_CHAN_A_ID, {26'h0, w});
        end
        // masks clear: channel a breaks only when the space id matches
        wr_reg(bcta_pkg::OFS_BREAK_CONTROL, 32'h0000_0000);
        for (int j = 0; j < 2; j++) begin
            wr_reg(bcta_pkg::OFS_CHAN_A_ID, {24'h0, sid ^ 8'(j)});
            na0 = na;
            @(posedge aclk);
            hit <= 1'b1;
            @(posedge aclk);
            hit <= 1'b0;
            repeat (4) @(posedge aclk);
            check("break_a_id", 34'(na - na0), 34'(j == 0));
        end
        wr_reg(8'h18, 32'h0);
        rd_reg(8'h18, {bcta_pkg::RESP_SLVERR, 32'h0});
        repeat (4) @(posedge aclk);
        tally_and_finish();
    end
endmodule
